/* rtl/serdes_tx_test_pattern_gen.v */
// transmit lane test pattern generator and lane control with apb registers
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "serdes_tx_test_map.vh"

module serdes_tx_test_pattern_gen
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        ce,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire        pslverr,
   output reg  [31:0] prdata,
   input  wire        power_down_pin,
   input  wire [63:0] fmt_data,
   input  wire        ila_done,
   input  wire        serdes_init_done,
   output reg  [63:0] lane_data_q,
   output reg  [7:0]  lane_oe_q,
   output reg         link_bypass_q,
   output reg         transport_off_q,
   output reg         sh_fec_en_q,
   output reg         sh_crc12_en_q,
   output reg         link_enable_q
);

   // ==========================================================
   // decode helpers
   // ==========================================================
   function [3:0] lanes_for_mode;
      input [3:0] m;
      begin
         case (m)
            `LMODE_0: lanes_for_mode = `LANES_MODE0;
            `LMODE_1: lanes_for_mode = `LANES_MODE1;
            `LMODE_2: lanes_for_mode = `LANES_MODE2;
            default:  lanes_for_mode = `LANES_DEFAULT;
         endcase
      end
   endfunction

   function [2:0] frame_last;
      input [3:0] m;
      begin
         case (m)
            `LMODE_0: frame_last = `FRAME_MODE0;
            `LMODE_1: frame_last = `FRAME_MODE1;
            default:  frame_last = 3'h0;
         endcase
      end
   endfunction

   // octet idx of the short transport frame of one lane
   function [7:0] short_octet;
      input [3:0] m;
      input [2:0] lane;
      input [2:0] idx;
      reg   [63:0] f;
      reg   [95:0] p;
      reg   [15:0] w;
      integer      j;
      begin
         f = 64'h0;
         p = `MODE1_PATTERN;
         w = 16'h0;
         short_octet = 8'h00;
         case (m)
            `LMODE_0:
            begin
               // five 12-bit words then a tail nibble
               for (j = 0; j < 5; j = j + 1)
                  f[63 - 12 * j -: 12] = {4'hf - {1'b0, lane},
                     {1'b0, lane}, j[3:0] + 4'h1};
               f[3:0] = `TAIL_NIBBLE;
               short_octet = f[63 - 8 * idx -: 8];
            end
            `LMODE_1:
            begin
               if (lane < 3'd6)
                  w = p[95 - 16 * lane -: 16];
               short_octet = idx[0] ? w[7:0] : w[15:8];
            end
            `LMODE_2:
               if (lane < 3'd4)
                  short_octet = {1'b0, lane, `MODE2_LOW_NIB};
            default:
               short_octet = 8'h00;
         endcase
      end
   endfunction

   // ==========================================================
   // apb slave, ready whenever ce is high, errors on unmapped addresses
   // ==========================================================
   reg  [31:0] ctrl_q;
   wire        setup   = psel & ~penable;
   wire        access  = psel & penable & ce;
   wire        hit_ctl = (paddr == `REG_CTRL);
   wire        hit_st  = (paddr == `REG_STATUS);
   wire [31:0] status_w;

   assign pready  = ce;
   assign pslverr = psel & penable & ~(hit_ctl | hit_st);

   // settings live only under presetn, power-down leaves them be
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_q <= `REG_CTRL_RESET;
      else if (access && pwrite && hit_ctl)
         ctrl_q <= pwdata & `CTRL_USED_MASK;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (ce && setup && !pwrite)
      begin
         if (hit_ctl)
            prdata <= ctrl_q;
         else if (hit_st)
            prdata <= status_w;
         else
            prdata <= 32'h0000_0000;
      end
   end

   wire [3:0] link_mode_select      = ctrl_q[`CTRL_MODE_LSB +: 4];
   wire [3:0] test_pattern_select   = ctrl_q[`CTRL_TEST_LSB +: 4];
   wire       alternate_lane_select = ctrl_q[`CTRL_ALT_BIT];
   wire       fec_sel               = ctrl_q[`CTRL_FEC_BIT];
   wire       link_en               = ctrl_q[`CTRL_LINKEN_BIT];
   wire       enc_66                = ctrl_q[`CTRL_ENC66_BIT];

   // ==========================================================
   // lane set selection
   // ==========================================================
   wire [3:0] lane_cnt  = lanes_for_mode(link_mode_select);
   wire       red_ok    = (lane_cnt <= `LANES_REDUNDANT);
   wire [7:0] base_mask = (8'h01 << lane_cnt[2:0]) - 8'h01;
   wire [7:0] full_mask = (lane_cnt[3]) ? 8'hff : base_mask;
   reg  [7:0] lane_mask;

   always @*
   begin
      // alternate set is the default set moved up, never both
      if (red_ok && alternate_lane_select)
         lane_mask = {full_mask[3:0], 4'h0};
      else
         lane_mask = full_mask;
   end

   // ==========================================================
   // mode decode
   // ==========================================================
   localparam [4:0] PM_OFF   = 5'b00001;
   localparam [4:0] PM_PRBS  = 5'b00010;
   localparam [4:0] PM_CLOCK = 5'b00100;
   localparam [4:0] PM_RAMP  = 5'b01000;
   localparam [4:0] PM_SHORT = 5'b10000;
   localparam [15:0] CLK_WORD = `CLOCK_WORD;

   reg [4:0] pat_mode;
   reg [2:0] poly;

   always @*
   begin
      poly = `PRBS_7;
      case (test_pattern_select)
         `TEST_PRBS7:  pat_mode = PM_PRBS;
         `TEST_PRBS9:
         begin
            pat_mode = PM_PRBS;
            poly     = `PRBS_9;
         end
         `TEST_PRBS15:
         begin
            pat_mode = PM_PRBS;
            poly     = `PRBS_15;
         end
         `TEST_PRBS23:
         begin
            pat_mode = PM_PRBS;
            poly     = `PRBS_23;
         end
         `TEST_PRBS31:
         begin
            pat_mode = PM_PRBS;
            poly     = `PRBS_31;
         end
         `TEST_CLOCK:  pat_mode = PM_CLOCK;
         `TEST_RAMP:   pat_mode = PM_RAMP;
         `TEST_SHORT:  pat_mode = PM_SHORT;
         default:      pat_mode = PM_OFF;
      endcase
   end

   // software is expected to change the selection with the link down;
   // a change at any time still restarts the generators cleanly
   reg [3:0] test_prev_q;
   wire      test_changed = (test_prev_q != test_pattern_select);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         test_prev_q <= `TEST_OFF;
      else if (ce)
         test_prev_q <= test_pattern_select;
   end

   // ==========================================================
   // prbs generators, one per lane with distinct seeds
   // ==========================================================
   wire [63:0] prbs_data;
   genvar k;
   generate
      for (k = 0; k < 8; k = k + 1)
      begin : g_prbs
         localparam [31:0] SEED_W = (k + 1) * 32'h0101_0101;
         prbs_octet_gen
         #(
            .SEED (SEED_W[30:0])
         )
         u_prbs
         (
            .pclk    (pclk),
            .presetn (presetn),
            .ce      (ce),
            .restart (test_changed),
            .poly    (poly),
            .octet_q (prbs_data[8 * k +: 8])
         );
      end
   endgenerate

   // ==========================================================
   // clock pattern, ramp and frame counters
   // ==========================================================
   reg       clk_half_q;
   reg [7:0] ramp_q;
   reg       ramp_run_q;
   reg [2:0] frame_idx_q;

   wire ramp_start = enc_66 ? serdes_init_done : ila_done;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clk_half_q  <= 1'b0;
         ramp_q      <= 8'h00;
         ramp_run_q  <= 1'b0;
         frame_idx_q <= 3'h0;
      end
      else if (ce)
      begin
         clk_half_q <= (pat_mode == PM_CLOCK) & ~clk_half_q;
         if (pat_mode != PM_RAMP || test_changed)
         begin
            ramp_run_q <= 1'b0;
            ramp_q     <= 8'h00;
         end
         else if (ramp_run_q || ramp_start)
         begin
            ramp_run_q <= 1'b1;
            ramp_q     <= ramp_q + 8'h01;
         end
         if (pat_mode != PM_SHORT ||
             frame_idx_q >= frame_last(link_mode_select))
            frame_idx_q <= 3'h0;
         else
            frame_idx_q <= frame_idx_q + 3'h1;
      end
   end

   // ==========================================================
   // lane data selection
   // ==========================================================
   reg [63:0] data_d;
   reg [63:0] short_data;
   integer    n;

   always @*
   begin
      short_data = 64'h0;
      for (n = 0; n < 8; n = n + 1)
         short_data[8 * n +: 8] = short_octet(link_mode_select,
            n[2:0], frame_idx_q);
      case (pat_mode)
         PM_PRBS:  data_d = prbs_data;
         PM_CLOCK: data_d = {8{clk_half_q ?
                      CLK_WORD[7:0] : CLK_WORD[15:8]}};
         PM_RAMP:  data_d = ramp_run_q ? {8{ramp_q}} : 64'h0;
         PM_SHORT: data_d = short_data;
         default:  data_d = fmt_data;
      endcase
   end

   // ==========================================================
   // output registers
   // ==========================================================
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lane_data_q     <= 64'h0;
         lane_oe_q       <= 8'h00;
         link_bypass_q   <= 1'b0;
         transport_off_q <= 1'b0;
         sh_fec_en_q     <= 1'b0;
         sh_crc12_en_q   <= 1'b0;
         link_enable_q   <= 1'b0;
      end
      else if (ce)
      begin
         // alternate lanes repeat the default data; unused lanes carry zero
         lane_data_q     <= (lane_mask[0] ? data_d : {data_d[31:0], 32'h0}) &
                                     {{8{lane_mask[7]}}, {8{lane_mask[6]}},
                                      {8{lane_mask[5]}}, {8{lane_mask[4]}},
                                      {8{lane_mask[3]}}, {8{lane_mask[2]}},
                                      {8{lane_mask[1]}}, {8{lane_mask[0]}}};
         lane_oe_q       <= power_down_pin ? 8'h00 : lane_mask;
         link_bypass_q   <= (pat_mode == PM_PRBS) ||
                            (pat_mode == PM_CLOCK);
         transport_off_q <= (pat_mode == PM_RAMP);
         // crc-12 with enc_66 set; fec replaces it when chosen; neither without enc_66
         sh_fec_en_q     <= enc_66 & fec_sel;
         sh_crc12_en_q   <= enc_66 & ~fec_sel;
         // link restart after power-down is left to the receiver
         link_enable_q   <= link_en & ~power_down_pin;
      end
   end

   assign status_w = {21'h0, ramp_run_q, red_ok, power_down_pin,
                      lane_oe_q};

endmodule
`default_nettype wire

/* rtl/serdes_tx_test_map.vh */
// offsets, fields, encodings and constants of the lane test pattern block
`ifndef SERDES_TX_TEST_MAP_VH
`define SERDES_TX_TEST_MAP_VH

// register byte addresses
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_CTRL_RESET  32'h0000_0000

// control fields
`define CTRL_MODE_LSB   0
`define CTRL_TEST_LSB   4
`define CTRL_ALT_BIT    8
`define CTRL_FEC_BIT    9
`define CTRL_LINKEN_BIT 10
`define CTRL_ENC66_BIT  11
`define CTRL_USED_MASK  32'h0000_0fff

// status fields
`define STAT_OE_LSB     0
`define STAT_PD_BIT     8
`define STAT_RED_BIT    9
`define STAT_RAMP_BIT   10

// test pattern selections
`define TEST_OFF        4'h0
`define TEST_PRBS7      4'h1
`define TEST_PRBS9      4'h2
`define TEST_PRBS15     4'h3
`define TEST_PRBS23     4'h4
`define TEST_PRBS31     4'h5
`define TEST_CLOCK      4'h6
`define TEST_RAMP       4'h7
`define TEST_SHORT      4'h8

// prbs generator polynomial selection
`define PRBS_7          3'h0
`define PRBS_9          3'h1
`define PRBS_15         3'h2
`define PRBS_23         3'h3
`define PRBS_31         3'h4

// link modes covered by the short transport patterns
`define LMODE_0         4'h0
`define LMODE_1         4'h1
`define LMODE_2         4'h2

// lane counts and the index of the last octet of each frame
`define LANES_MODE0     4'h8
`define LANES_MODE1     4'h6
`define LANES_MODE2     4'h4
`define LANES_DEFAULT   4'h8
`define LANES_REDUNDANT 4'h4
`define FRAME_MODE0     3'h7
`define FRAME_MODE1     3'h1

// pattern constants
`define CLOCK_WORD      16'hff00
`define TAIL_NIBBLE     4'h0
`define MODE1_PATTERN   96'hf01f_02e1_1e12_d21d_22c3_1c32
`define MODE2_LOW_NIB   4'h1

`endif

/* rtl/prbs_octet_gen.v */
// one lane prbs generator, eight bits per clock, msb sent first
`timescale 1ns/1ps
`default_nettype none
`include "serdes_tx_test_map.vh"

module prbs_octet_gen
#(
   parameter [30:0] SEED = 31'h0000_0001
)
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        ce,
   input  wire        restart,
   input  wire [2:0]  poly,
   output reg  [7:0]  octet_q
);

   reg  [30:0] state_q;
   reg  [30:0] state_d;
   reg  [7:0]  octet_d;
   reg  [30:0] live_mask;
   reg  [4:0]  tap_a;
   reg  [4:0]  tap_b;
   reg         nb;
   integer     i;

   // y[n] = y[n-1-a] ^ y[n-1-b] for taps a, b; state bit k holds y[n-1-k]
   always @*
   begin
      tap_a     = 5'd5;
      tap_b     = 5'd6;
      live_mask = 31'h0000_007f;
      nb        = 1'b0;
      case (poly)
         `PRBS_7:
         begin
            tap_a     = 5'd5;
            tap_b     = 5'd6;
            live_mask = 31'h0000_007f;
         end
         `PRBS_9:
         begin
            tap_a     = 5'd4;
            tap_b     = 5'd8;
            live_mask = 31'h0000_01ff;
         end
         `PRBS_15:
         begin
            tap_a     = 5'd13;
            tap_b     = 5'd14;
            live_mask = 31'h0000_7fff;
         end
         `PRBS_23:
         begin
            tap_a     = 5'd17;
            tap_b     = 5'd22;
            live_mask = 31'h007f_ffff;
         end
         default:
         begin
            tap_a     = 5'd27;
            tap_b     = 5'd30;
            live_mask = 31'h7fff_ffff;
         end
      endcase
      state_d = state_q;
      // a dead all-zero register is reseeded rather than left stuck
      if (restart || ((state_q & live_mask) == 31'h0000_0000))
         state_d = SEED;
      octet_d = 8'h00;
      for (i = 0; i < 8; i = i + 1)
      begin
         nb         = state_d[tap_a] ^ state_d[tap_b];
         state_d    = {state_d[29:0], nb};
         octet_d[7 - i] = nb;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= 31'h0000_0001;
         octet_q <= 8'h00;
      end
      else if (ce)
      begin
         state_q <= state_d;
         octet_q <= octet_d;
      end
   end

endmodule
`default_nettype wire

/* verif/serdes_tx_test_pattern_gen_asserts.sv */
// port assertions for the lane test pattern block
`timescale 1ns/1ps
`default_nettype none
module serdes_tx_test_pattern_gen_asserts
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   input wire logic        power_down_pin,
   input wire logic [63:0] fmt_data,
   input wire logic        ila_done,
   input wire logic        serdes_init_done,
   input wire logic [63:0] lane_data_q,
   input wire logic [7:0]  lane_oe_q,
   input wire logic        link_bypass_q,
   input wire logic        transport_off_q,
   input wire logic        sh_fec_en_q,
   input wire logic        sh_crc12_en_q,
   input wire logic        link_enable_q
);
   // ==========================================================
   // shadow of the control word, one cycle history
   logic [11:0] ctrl_q;
   logic [11:0] pctl_q;
   logic        ppd_q;
   logic [7:0]  poct_q;
   wire  [3:0]  tst = ctrl_q[7:4];
   wire  [15:0] bits = {poct_q, lane_data_q[7:0]};
   wire         go = ctrl_q[11] ? serdes_init_done : ila_done;
   wire         wr0 = psel & penable & pwrite & ce & (paddr == 12'h000);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= 12'h000;
         pctl_q <= 12'h000;
         ppd_q  <= 1'b0;
         poct_q <= 8'h00;
      end
      else
      begin
         if (wr0)
            ctrl_q <= pwdata[11:0];
         pctl_q <= ctrl_q;
         ppd_q  <= power_down_pin;
         poct_q <= lane_data_q[7:0];
      end
   end

   // alternate select only counts when four lanes or fewer
   function automatic logic [7:0] oe_exp(input logic [11:0] c);
      case (c[3:0])
         4'h1: oe_exp = 8'h3f;
         4'h2: oe_exp = c[8] ? 8'hf0 : 8'h0f;
         default: oe_exp = 8'hff;
      endcase
   endfunction

   // ==========================================================
   // properties
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_oe;
      presetn |=> lane_oe_q == (ppd_q ? 8'h00 : oe_exp(pctl_q));
   endproperty
   a_oe: assert property (p_oe) else $error("lane enables");
   property p_short2;
      (tst == 4'h8 && ctrl_q[3:0] == 4'h2 && !power_down_pin)[*3]
      |=> lane_data_q == 64'h0000_0000_3121_1101;
   endproperty
   a_short2: assert property (p_short2) else $error("short mode 2");
   property p_clk;
      (tst == 4'h6 && !power_down_pin)[*3] |=> lane_data_q[7:0] ==
         ~$past(lane_data_q[7:0]) && lane_data_q[0] == lane_data_q[7];
   endproperty
   a_clk: assert property (p_clk) else $error("clock pattern");
   property p_ramp;
      (tst == 4'h7 && go && !power_down_pin && ce)[*3] |=> lane_data_q[7:0] ==
         $past(lane_data_q[7:0]) + 8'h01 && lane_data_q[15:8] == lane_data_q[7:0];
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp step");
   property p_prbs7;
      (tst == 4'h1 && !power_down_pin)[*5] |-> bits[7:0] == (bits[13:6] ^ bits[14:7]);
   endproperty
   a_prbs7: assert property (p_prbs7) else $error("prbs7 taps");
   property p_path;
      1'b1 |=> transport_off_q == (pctl_q[7:4] == 4'h7) && link_bypass_q ==
         (pctl_q[7:4] >= 4'h1 && pctl_q[7:4] <= 4'h6);
   endproperty
   a_path: assert property (p_path) else $error("layer bypass");
   property p_sh;
      1'b1 |=> sh_fec_en_q == (pctl_q[11] & pctl_q[9]) &&
         sh_crc12_en_q == (pctl_q[11] & ~pctl_q[9]);
   endproperty
   a_sh: assert property (p_sh) else $error("sync header select");
   property p_link;
      1'b1 |=> link_enable_q == (pctl_q[10] & ~ppd_q);
   endproperty
   a_link: assert property (p_link) else $error("link enable");
   property p_apb;
      psel && penable |-> pready == ce &&
         pslverr == (paddr != 12'h000 && paddr != 12'h004);
   endproperty
   a_apb: assert property (p_apb) else $error("apb response");
   c_short2: cover property (tst == 4'h8 && ctrl_q[3:0] == 4'h2);
   c_ramp: cover property (tst == 4'h7 && go);
   c_pd: cover property (power_down_pin && lane_oe_q == 8'h00);
endmodule

bind serdes_tx_test_pattern_gen serdes_tx_test_pattern_gen_asserts chk
(
   .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .pslverr, .prdata, .power_down_pin, .fmt_data, .ila_done,
   .serdes_init_done, .lane_data_q, .lane_oe_q, .link_bypass_q,
   .transport_off_q, .sh_fec_en_q, .sh_crc12_en_q, .link_enable_q
);
`default_nettype wire

/* verif/lane_rx_model.sv */
// far end lane receiver model that relinks after power-down
`timescale 1ns/1ps
`default_nettype none
module lane_rx_model
#(
   parameter int FLUSH = 16
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [63:0] lane_data,
   input  wire logic [7:0]  lane_oe,
   input  wire logic        link_up,
   output var  logic        rx_ready,
   output var  logic [7:0]  rx_octet
);
   int wait_q;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wait_q   <= FLUSH;
         rx_ready <= 1'b0;
         rx_octet <= 8'h00;
      end
      else
      begin
         // stale pipeline data is dropped until the flush count ends
         if (!link_up || lane_oe[0] !== 1'b1)
            wait_q <= FLUSH;
         else if (wait_q != 0)
            wait_q <= wait_q - 1;
         rx_ready <= (wait_q == 0);
         // an undriven lane shows no stable level
         rx_octet <= lane_oe[0] ? lane_data[7:0] : ~rx_octet;
      end
   end
endmodule
`default_nettype wire

/* verif/serdes_tx_test_pattern_gen_tb_top.sv */
// self-checking bench for the lane test pattern block
`timescale 1ns/1ps
`default_nettype none
`include "serdes_tx_test_map.vh"
module serdes_tx_test_pattern_gen_tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        ce = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        power_down_pin = 1'b0;
   logic [63:0] fmt_data = 64'h0123_4567_89ab_cdef;
   logic        ila_done = 1'b0;
   logic        serdes_init_done = 1'b0;
   wire         pready, pslverr, rx_ready;
   wire  [31:0] prdata;
   wire  [63:0] lane_data_q;
   wire  [7:0]  lane_oe_q, rx_octet;
   wire         link_bypass_q, transport_off_q, link_enable_q;
   wire         sh_fec_en_q, sh_crc12_en_q;
   int          fail_count = 0;
   int          comparisons = 0;
   logic [31:0] rd;
   logic        err;
   logic [7:0]  x;

   serdes_tx_test_pattern_gen uut
   (
      .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .pslverr, .prdata, .power_down_pin, .fmt_data, .ila_done,
      .serdes_init_done, .lane_data_q, .lane_oe_q, .link_bypass_q,
      .transport_off_q, .sh_fec_en_q, .sh_crc12_en_q, .link_enable_q
   );
   lane_rx_model #(.FLUSH(16)) rx
   (
      .pclk, .presetn, .lane_data(lane_data_q), .lane_oe(lane_oe_q),
      .link_up(link_enable_q), .rx_ready, .rx_octet
   );

   always #12.5 pclk = ~pclk;

   // ==========================================================
   // tasks
   task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge pclk);
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no wait limit here: the watchdog ends a hung access
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // a frame may be caught at any phase, so any rotation matches
   task automatic frame_chk(input int l, input int n, input logic [63:0] exp);
      logic [63:0] m;
      logic [63:0] v;
      logic [63:0] hit;
      m = (n == 8) ? '1 : ((64'h1 << (8 * n)) - 64'h1);
      v = 64'h0;
      tick(3);
      for (int i = 0; i < n; i++)
      begin
         tick(1);
         v = (v << 8) | lane_data_q[8*l +: 8];
      end
      hit = v;
      for (int r = 0; r < n; r++)
         if ((((v << (8 * r)) | (v >> (8 * (n - r)))) & m) === exp)
            hit = exp;
      check_val(hit, exp);
   endtask

   task automatic prbs_chk(input logic [3:0] code, input int a, input int b);
      logic [63:0] h;
      logic [63:0] h1;
      int bad;
      bad = 0;
      h = 64'h0;
      h1 = 64'h0;
      apb(1'b1, `REG_CTRL, {24'h0, code, 4'h0});
      tick(6);
      for (int k = 0; k < 12; k++)
      begin
         tick(1);
         h = {h[55:0], lane_data_q[7:0]};
         h1 = {h1[55:0], lane_data_q[15:8]};
         for (int i = 0; i < 8; i++)
            if (k > 4 && h[i] !== (h[i + a] ^ h[i + b]))
               bad++;
      end
      check_val(bad, 0);
      check_val({h == 64'h0, h == h1, link_bypass_q}, 3'b001);
   endtask

   task automatic results;
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ==========================================================
   // tests
   initial
   begin
      #(25 * 6000);
      fail_count++;
      results();
   end

   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `REG_CTRL, 32'h0);
      check_val({err, rd}, 33'h0);
      apb(1'b1, 12'h008, 32'hffff_ffff);
      check_val(err, 1'b1);
      apb(1'b0, 12'h00c, 32'h0);
      check_val({err, rd}, 33'h1_0000_0000);
      apb(1'b1, `REG_STATUS, 32'hffff_ffff);
      apb(1'b0, `REG_STATUS, 32'h0);
      check_val({err, rd}, 33'h0_0000_00ff);
      check_val(lane_data_q, fmt_data);
      apb(1'b1, `REG_CTRL, 32'h102);
      tick(3);
      check_val(lane_oe_q, 8'hf0);
      check_val(lane_data_q, {fmt_data[31:0], 32'h0});
      apb(1'b0, `REG_STATUS, 32'h0);
      check_val(rd, 32'h0000_02f0);
      apb(1'b1, `REG_CTRL, 32'h002);
      tick(3);
      check_val({lane_oe_q, lane_data_q[31:0]}, 40'h0f_89ab_cdef);
      apb(1'b1, `REG_CTRL, 32'h101);
      tick(3);
      check_val(lane_oe_q, 8'h3f);
      apb(1'b1, `REG_CTRL, 32'h080);
      frame_chk(0, 8, 64'hf01f_02f0_3f04_f050);
      frame_chk(7, 8, 64'h8718_7287_3874_8750);
      apb(1'b1, `REG_CTRL, 32'h081);
      frame_chk(0, 2, 64'hf01f);
      frame_chk(5, 2, 64'h1c32);
      apb(1'b1, `REG_CTRL, 32'h082);
      frame_chk(3, 1, 64'h31);
      check_val(lane_data_q, 64'h3121_1101);
      apb(1'b1, `REG_CTRL, 32'h060);
      frame_chk(0, 2, 64'hff00);
      frame_chk(6, 2, 64'hff00);
      prbs_chk(4'h1, 6, 7);
      prbs_chk(4'h2, 5, 9);
      prbs_chk(4'h3, 14, 15);
      prbs_chk(4'h4, 18, 23);
      prbs_chk(4'h5, 28, 31);
      apb(1'b1, `REG_CTRL, 32'h070);
      tick(4);
      check_val({transport_off_q, lane_data_q[31:0]}, 33'h1_0000_0000);
      @(posedge pclk);
      ila_done <= 1'b1;
      tick(300);
      x = lane_data_q[7:0];
      tick(1);
      check_val(lane_data_q, {8{x + 8'h01}});
      @(posedge pclk);
      ce <= 1'b0;
      tick(4);
      check_val(lane_data_q, {8{x + 8'h02}});
      @(posedge pclk);
      ce <= 1'b1;
      // leave ramp first so the new encoding waits for its own start
      apb(1'b1, `REG_CTRL, 32'h800);
      apb(1'b1, `REG_CTRL, 32'h870);
      tick(4);
      check_val(lane_data_q[7:0], 8'h00);
      @(posedge pclk);
      serdes_init_done <= 1'b1;
      tick(5);
      check_val(lane_data_q[7:0] == 8'h00, 1'b0);
      for (int f = 0; f < 2; f++)
      begin
         apb(1'b1, `REG_CTRL, 32'h800 | (f << 9));
         tick(3);
         check_val({sh_fec_en_q, sh_crc12_en_q}, f ? 2'b10 : 2'b01);
      end
      apb(1'b1, `REG_CTRL, 32'h482);
      tick(30);
      check_val({rx_ready, rx_octet}, 9'h101);
      @(posedge pclk);
      power_down_pin <= 1'b1;
      tick(4);
      check_val({lane_oe_q, link_enable_q, rx_ready}, 10'h0);
      apb(1'b0, `REG_CTRL, 32'h0);
      check_val(rd, 32'h0000_0482);
      apb(1'b0, `REG_STATUS, 32'h0);
      check_val(rd, 32'h0000_0300);
      @(posedge pclk);
      power_down_pin <= 1'b0;
      tick(3);
      check_val({lane_oe_q, link_enable_q, rx_ready}, 10'h03e);
      tick(25);
      check_val({rx_ready, rx_octet}, 9'h101);
      results();
   end
endmodule
`default_nettype wire
